// ==== gpo_port.sv ====
// file: eight-bit general purpose port with apb registers and pin overrides
// ==========================================================
// Summary of operation
// - eight pins, each with its own direction bit.
// - direction bit 1 turns the pin driver off; pin is an input.
// - direction bit 0 drives the pin from its output latch bit.
// - latch register is addressable; reads return latch, writes update it.
// - after reset every pin is an input with drivers off.
// - control bit 4 turns the whole port into a parallel processor port.
// - parallel mode drives the latch onto pins during an external read.
// - parallel mode takes all eight pin levels as external write data.
// - parallel mode ignores direction bits; parallel logic decides direction.
// - pins 5..7 carry pwm channels b..d, overriding port and parallel data.
// - a pwm channel reaches its pin only while its direction bit is 0.
// - pwm shutdown may tristate pwm pins when configured.
// - dual or quad pwm output disables parallel-port functions.
`timescale 1ns/1ns
`default_nettype none
module gpo_port
    import gpo_pkg::*;
(
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // port pins
    input  wire logic [7:0]  pin_in,
    output logic [7:0]       pin_out,
    output logic [7:0]       pin_oe,
    // parallel interface: strobes from the external processor in, captured write byte and valid out
    input  wire logic        par_read_strobe,
    input  wire logic        par_write_strobe,
    output logic [7:0]       par_write_data,
    output logic             par_write_valid,
    // enhanced pwm unit
    input  wire logic [2:0]  pwm_chan,
    input  wire logic        pwm_shut_active,
    input  wire logic        pwm_run
);

    // ==========================================================
    // registers
    logic [7:0] latch;
    logic [7:0] direction;
    logic [7:0] par_ctrl;
    logic [7:0] pwm_ctrl;
    logic [7:0] pwm_shut;
    logic [7:0] pin_sample;

    // ==========================================================
    // apb decode
    function automatic logic addr_known(input logic [11:0] a);
        addr_known = (a == OFF_PIN_DATA) || (a == OFF_LATCH) ||
                     (a == OFF_DIRECTION) || (a == OFF_PAR_CTRL) ||
                     (a == OFF_PWM_CTRL) || (a == OFF_PWM_SHUT);
    endfunction

    logic setup;
    logic wr_go;
    logic lane0;
    assign setup = psel && !penable;
    assign wr_go = psel && penable && pready && pwrite && clk_en;
    assign lane0 = pstrb[0];

    // ==========================================================
    // mode derivation
    logic [1:0] pwm_cfg;
    logic       pwm_multi;
    logic       par_mode;
    assign pwm_cfg   = {pwm_ctrl[BIT_PWM_CFG_HI], pwm_ctrl[BIT_PWM_CFG_LO]};
    assign pwm_multi = pwm_run && (pwm_cfg != PWM_SINGLE);
    // parallel mode is suppressed by multi-output pwm, not by clearing the bit
    assign par_mode  = par_ctrl[BIT_PAR_MODE] && !pwm_multi;

    // ==========================================================
    // pin sampling; inputs are synchronous so one register stage suffices
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sample <= ZERO8;
        end else if (clk_en) begin
            pin_sample <= pin_in;
        end
    end

    // output latch, written through either data or latch address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch <= ZERO8;
        end else if (wr_go && lane0 &&
                     (paddr == OFF_LATCH || paddr == OFF_PIN_DATA)) begin
            latch <= pwdata[7:0];
        end
    end

    // direction register; all ones after reset keeps every driver off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direction <= DIR_RESET;
        end else if (wr_go && lane0 && paddr == OFF_DIRECTION) begin
            direction <= pwdata[7:0];
        end
    end

    // control registers; status bits of the parallel control stay read-only zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            par_ctrl <= PAR_CTRL_RESET;
            pwm_ctrl <= ZERO8;
            pwm_shut <= ZERO8;
        end else if (wr_go && lane0) begin
            if (paddr == OFF_PAR_CTRL) begin
                par_ctrl <= pwdata[7:0] & PAR_CTRL_WMASK;
            end
            if (paddr == OFF_PWM_CTRL) begin
                pwm_ctrl <= pwdata[7:0];
            end
            if (paddr == OFF_PWM_SHUT) begin
                pwm_shut <= pwdata[7:0];
            end
        end
    end

    // ==========================================================
    // apb answer: no wait state, ready in the first access cycle
    logic [7:0] rd_mux;
    always_comb begin
        unique case (paddr)
            OFF_PIN_DATA:  rd_mux = pin_sample;
            OFF_LATCH:     rd_mux = latch;
            OFF_DIRECTION: rd_mux = direction;
            OFF_PAR_CTRL:  rd_mux = par_ctrl;
            OFF_PWM_CTRL:  rd_mux = pwm_ctrl;
            OFF_PWM_SHUT:  rd_mux = pwm_shut;
            default:       rd_mux = ZERO8;
        endcase
    end

    // ready is raised from setup so it stands for exactly one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= ZERO32;
        end else if (clk_en) begin
            pready  <= setup;
            pslverr <= setup && !addr_known(paddr);
            if (setup && !pwrite) begin
                prdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // ==========================================================
    // parallel write capture: the external processor's byte from the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            par_write_data  <= ZERO8;
            par_write_valid <= 1'b0;
        end else if (clk_en) begin
            par_write_valid <= par_mode && par_write_strobe;
            if (par_mode && par_write_strobe) begin
                par_write_data <= pin_in;
            end
        end
    end

    // ==========================================================
    // pin drive resolution
    gpo_par_s  par;
    gpo_pwm_s  pwm;
    gpo_pins_s pins;
    assign par.read_drive  = par_read_strobe && !par_write_strobe;
    assign par.write_take  = par_write_strobe;
    assign pwm.chan        = pwm_chan;
    assign pwm.shut_active = pwm_shut_active;
    assign pwm.run         = pwm_run;

    gpo_pin_mux u_mux (
        .latch         (latch),
        .direction     (direction),
        .par_mode      (par_mode),
        .par           (par),
        .pwm           (pwm),
        .shut_tristate (pwm_shut[BIT_SHUT_TRI]),
        .pwm_cfg       (pwm_cfg),
        .pins          (pins)
    );

    // registered pin drivers; reset leaves every driver off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= ZERO8;
            pin_oe  <= ZERO8;
        end else if (clk_en) begin
            pin_out <= pins.dout;
            pin_oe  <= pins.oe;
        end
    end

endmodule
`default_nettype wire

// ==== gpo_pkg.sv ====
// package: register map, field layout and pin-mux types for the eight-bit port
package gpo_pkg;

    // ==========================================================
    // register offsets (byte addresses on the apb bus)
    localparam logic [11:0] OFF_PIN_DATA  = 12'h000;
    localparam logic [11:0] OFF_LATCH     = 12'h004;
    localparam logic [11:0] OFF_DIRECTION = 12'h008;
    localparam logic [11:0] OFF_PAR_CTRL  = 12'h00C;
    localparam logic [11:0] OFF_PWM_CTRL  = 12'h010;
    localparam logic [11:0] OFF_PWM_SHUT  = 12'h014;

    // ==========================================================
    // field layout and reset values
    localparam int          PORT_W          = 8;
    localparam int          BIT_PAR_MODE    = 4;
    localparam int          BIT_PWM_CFG_HI  = 7;
    localparam int          BIT_PWM_CFG_LO  = 6;
    localparam int          BIT_SHUT_TRI    = 0;
    localparam int          PWM_PIN_FIRST   = 5;
    localparam logic [7:0]  PAR_CTRL_WMASK  = 8'h37;
    localparam logic [7:0]  DIR_RESET       = 8'hFF;
    localparam logic [7:0]  PAR_CTRL_RESET  = 8'h07;
    localparam logic [7:0]  ZERO8           = 8'h00;
    localparam logic [31:0] ZERO32          = 32'h0000_0000;

    // pwm output configuration (hi,lo): single, full fwd, half, full rev
    localparam logic [1:0]  PWM_SINGLE      = 2'h0;

    // ==========================================================
    // carrier types
    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe;
    } gpo_pins_s;

    typedef struct packed {
        logic [2:0] chan;        // channel outputs d,c,b
        logic       shut_active; // shutdown event in progress
        logic       run;         // pwm mode is active
    } gpo_pwm_s;

    typedef struct packed {
        logic       read_drive;  // external processor is reading the port
        logic       write_take;  // external processor is writing the port
    } gpo_par_s;

endpackage

// ==== gpo_pin_mux.sv ====
// file: per-pin output priority mux for port, parallel and pwm sources
`timescale 1ns/1ns
`default_nettype none
module gpo_pin_mux
    import gpo_pkg::*;
(
    // register state
    input  wire logic [7:0] latch,
    input  wire logic [7:0] direction,
    // mode and overrides
    input  wire logic       par_mode,
    input  wire gpo_par_s   par,
    input  wire gpo_pwm_s   pwm,
    input  wire logic       shut_tristate,
    input  wire logic [1:0] pwm_cfg,
    // resolved pin drive
    output gpo_pins_s       pins
);

    // pwm owns the upper three pins only in dual or quad output mode
    logic pwm_multi;
    assign pwm_multi = pwm.run && (pwm_cfg != PWM_SINGLE);

    // per-pin results gathered into plain vectors; each bit has one driver
    logic [7:0] dout_v;
    logic [7:0] oe_v;

    // one mux per pin; pwm beats parallel port which beats plain port data
    genvar i;
    generate
        for (i = 0; i < PORT_W; i++) begin : g_pin
            logic pwm_here;
            logic pwm_val;
            logic dout_bit;
            logic oe_bit;
            // only the upper pins own a pwm channel; lower pins never index it
            if (i >= PWM_PIN_FIRST) begin : g_pwm
                assign pwm_here = pwm_multi && !direction[i];
                assign pwm_val  = pwm.chan[i - PWM_PIN_FIRST];
            end else begin : g_plain
                assign pwm_here = 1'b0;
                assign pwm_val  = 1'b0;
            end
            always_comb begin
                dout_bit = latch[i];
                oe_bit   = ~direction[i];
                if (par_mode) begin
                    oe_bit = par.read_drive;
                end
                if (pwm_here) begin
                    dout_bit = pwm_val;
                    oe_bit   = !(pwm.shut_active && shut_tristate);
                end
            end
            assign dout_v[i] = dout_bit;
            assign oe_v[i]   = oe_bit;
        end
    endgenerate

    // hand the resolved drive out as one carrier
    assign pins.dout = dout_v;
    assign pins.oe   = oe_v;

endmodule
`default_nettype wire

// ==== gpo_port_props.sv ====
// checker: port-level timing rules of the eight-bit port
`timescale 1ns/1ns
`default_nettype none
module gpo_port_props (
    // clock and control
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       clk_en,
    // bus handshake
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    // pins and parallel capture
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic       par_write_strobe,
    input wire logic [7:0] par_write_data,
    input wire logic       par_write_valid
);
    // ==========================================================
    // one clock domain, so one default clocking and reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_reset_inputs: assert property ($rose(presetn) |-> (pin_oe == 8'h00) [*2])
        else $error("pins driven just after reset");
    chk_ready_setup: assert property (psel && !penable && clk_en |=> pready)
        else $error("no ready in first access cycle");
    chk_ready_pulse: assert property (pready && clk_en |=> !pready)
        else $error("ready held too long");
    chk_err_pair: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_idle_ready: assert property (!psel |=> !pready)
        else $error("ready without selection");
    chk_valid_cause: assert property (par_write_valid |-> $past(par_write_strobe))
        else $error("capture without strobe");
    chk_par_data: assert property (par_write_valid |-> par_write_data == $past(pin_in))
        else $error("captured data differs from pins");
    chk_freeze_pins: assert property (!clk_en |=> $stable(pin_oe) && $stable(pin_out))
        else $error("pins moved while frozen");
endmodule

bind gpo_port gpo_port_props u_props (.pclk, .presetn, .clk_en, .psel, .penable, .pready,
    .pslverr, .pin_in, .pin_out, .pin_oe, .par_write_strobe, .par_write_data, .par_write_valid);
`default_nettype wire

// ==== gpo_pin_model.sv ====
// model: external circuitry attached to the eight port pins
`timescale 1ns/1ns
`default_nettype none
module gpo_pin_model (
    // design side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    // external drivers
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    // resolved wire levels
    output logic [7:0]      pin_in
);
    // an undriven pin shows the inverse, so a stale value can never pass
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else
                pin_in[i] = ~pin_out[i];
        end
    end
endmodule
`default_nettype wire

// ==== tb_gpo_port.sv ====
// testbench: register, pin, parallel and pwm scenarios for the port
`timescale 1ns/1ns
`default_nettype none
module tb_gpo_port;
    import gpo_pkg::*;
    logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [3:0]  pstrb = 4'h1;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic        pready, pslverr, rerr, par_write_valid;
    logic        par_read_strobe = 0, par_write_strobe = 0, pwm_shut_active = 0, pwm_run = 0;
    logic [2:0]  pwm_chan = 3'h2;
    logic [7:0]  pin_in, pin_out, pin_oe, par_write_data, ext_val = '0, ext_en = '0;
    int          err_count = 0, checks = 0, cyc = 0;

    // ==========================================================
    // clock, hang guard and instances
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            close_out();
        end
    end
    gpo_port u_gpo_port (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .par_read_strobe,
        .par_write_strobe, .par_write_data, .par_write_valid, .pwm_chan, .pwm_shut_active,
        .pwm_run);
    gpo_pin_model u_gpo_pin_model (.pin_out, .pin_oe, .ext_val, .ext_en, .pin_in);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, entered just after an edge; idles one cycle after release
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        // only the hang guard ends a wait that never sees ready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        apb(0, a, 8'h00);
        check(rdat, {24'h0, exp});
        check({31'h0, rerr}, 32'h0);
    endtask
    // drive updates one cycle after their cause, so two edges is settled
    task automatic pins(input logic [7:0] oe, input logic [7:0] out);
        repeat (2) @(posedge pclk);
        check({24'h0, pin_oe}, {24'h0, oe});
        check({24'h0, pin_out & pin_oe}, {24'h0, out});
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        check({24'h0, pin_oe}, 32'h0);
        rd(OFF_DIRECTION, DIR_RESET);
        rd(OFF_PAR_CTRL, PAR_CTRL_RESET);
        apb(1, OFF_PIN_DATA, 8'hA5);
        rd(OFF_LATCH, 8'hA5);
        pstrb <= 4'h0;
        apb(1, OFF_LATCH, 8'h00);
        pstrb <= 4'h1;
        rd(OFF_LATCH, 8'hA5);
        apb(1, OFF_DIRECTION, 8'h0F);
        ext_val <= 8'h3C;
        ext_en <= 8'h0F;
        pins(8'hF0, 8'hA0);
        rd(OFF_PIN_DATA, 8'hAC);
        rd(OFF_LATCH, 8'hA5);
        apb(0, 12'h020, 8'h00);
        check({31'h0, rerr}, 32'h1);
        apb(1, OFF_PAR_CTRL, 8'hFF);
        rd(OFF_PAR_CTRL, 8'h37);
        pins(8'h00, 8'h00);
        par_read_strobe <= 1;
        pins(8'hFF, 8'hA5);
        par_read_strobe <= 0;
        ext_val <= 8'h5A;
        ext_en <= 8'hFF;
        @(posedge pclk);
        par_write_strobe <= 1;
        @(posedge pclk);
        par_write_strobe <= 0;
        @(posedge pclk);
        check({31'h0, par_write_valid}, 32'h1);
        check({24'h0, par_write_data}, 32'h5A);
        apb(1, OFF_PWM_CTRL, 8'h40);
        pwm_run <= 1;
        pins(8'hF0, 8'h40);
        apb(1, OFF_DIRECTION, 8'hEF);
        pins(8'h10, 8'h00);
        apb(1, OFF_DIRECTION, 8'h0F);
        pins(8'hF0, 8'h40);
        pwm_shut_active <= 1;
        pins(8'hF0, 8'h40);
        apb(1, OFF_PWM_SHUT, 8'h01);
        pwm_shut_active <= 1;
        pins(8'h10, 8'h00);
        clk_en <= 0;
        pwm_shut_active <= 0;
        pins(8'h10, 8'h00);
        clk_en <= 1;
        pins(8'hF0, 8'h40);
        close_out();
    end
endmodule
`default_nettype wire
